// ---- rtl/ubt_pkg.sv ----
// Constants and carrier types shared by the baud and timing register block.
// Assumes a 25 MHz ref_clk_i and a plain address/strobe register port.
package ubt_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_TX_HOLDING = 8'h00;
  localparam logic [7:0] ADDR_BAUD_DIV = 8'h04;
  localparam logic [7:0] ADDR_RX_TIMEOUT = 8'h08;
  localparam logic [7:0] ADDR_GUARD = 8'h0c;
  localparam logic [7:0] ADDR_RATIO = 8'h10;
  localparam logic [7:0] ADDR_ERR_CNT = 8'h14;
  localparam logic [7:0] ADDR_IR_FILT = 8'h18;
  localparam logic [7:0] ADDR_MODE = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int TXC_MSB = 8;
  localparam int TXSYNC_BIT = 15;
  localparam int DIV_MSB = 15;
  localparam int FRAC_LSB = 16;
  localparam int FRAC_MSB = 18;
  localparam int TO_MSB = 15;
  localparam int GUARD_MSB = 7;
  localparam int RATIO_MSB = 10;
  localparam int ERR_MSB = 7;
  localparam int IRF_MSB = 7;
  localparam int MODE_MSB = 2;
  localparam int MODE_START_TO_BIT = 3;
  localparam int IRQ_MSB = 2;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_CARD_ERR = 1;
  localparam int IRQ_TX_FREE = 2;
  localparam int MODE_SYNC = 0;
  localparam int MODE_OVER8 = 1;
  localparam int MODE_CARD = 2;

  // ----------------------------------------
  // Reset values, error count limit and divider scaling
  // ----------------------------------------
  localparam logic [10:0] RATIO_RST = 11'h174;
  localparam logic [7:0] ERR_MAX = 8'hff;
  localparam int SHIFT_X16 = 4;
  localparam int SHIFT_X8 = 3;
  localparam int FRAC_X16 = 1;
  localparam int FRAC_X8 = 0;

  // ----------------------------------------
  // Carriers and states
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ubt_bus_type;

  typedef struct packed {
    logic [15:0] clock_divisor;
    logic [2:0] fraction_part;
    logic sync;
    logic over8;
    logic card;
    logic [10:0] ratio;
  } ubt_baud_cfg_type;

  typedef enum logic [1:0] {
    TXS_IDLE = 2'b01,
    TXS_GUARD = 2'b10
  } ubt_tx_state_type;
endpackage : ubt_pkg

// ---- rtl/ubt_baud_gen.sv ----
// Baud generator: one-cycle bit-period tick from the divider settings.
// Assumes the selected clock is ref_clk_i itself.
`timescale 1ns/1ps
`default_nettype none
module ubt_baud_gen (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire ubt_pkg::ubt_baud_cfg_type cfg_i,
  output logic tick_o
);
  import ubt_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } ubt_bg_state_type;

  ubt_bg_state_type st_ff;
  ubt_bg_state_type nxt_st;
  logic [31:0] period;

  always_comb begin
    period = 32'h0;
    if (cfg_i.clock_divisor == 16'h0) begin
      period = 32'h0;
    end else if (cfg_i.card) begin
      period = {16'h0, cfg_i.clock_divisor} * {21'h0, cfg_i.ratio};
    end else if (cfg_i.sync) begin
      period = {16'h0, cfg_i.clock_divisor};
    end else if (cfg_i.over8) begin
      period = ({16'h0, cfg_i.clock_divisor} << SHIFT_X8) + ({29'h0, cfg_i.fraction_part} << FRAC_X8);
    end else begin
      period = ({16'h0, cfg_i.clock_divisor} << SHIFT_X16) + ({29'h0, cfg_i.fraction_part} << FRAC_X16);
    end
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (period == 32'h0) begin
      nxt_st.cnt = 32'h0;
    end else if (st_ff.cnt >= period - 32'h1) begin
      // A shrunk divisor restarts the count instead of wrapping
      nxt_st.cnt = 32'h0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;

  a_baud_stop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (period == 32'h0) |=> !tick_o)
    else $error("baud tick with divider stopped");

  a_baud_gap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tick_o && period > 32'h1 && $stable(cfg_i)) |=> !tick_o)
    else $error("baud ticks back to back");
endmodule : ubt_baud_gen
`default_nettype wire

// ---- rtl/ubt_ir_filter.sv ----
// Infrared receive glitch filter: a level change passes once stable long enough.
// Assumes ir_i is synchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module ubt_ir_filter (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] filt_i,
  input wire logic ir_i,
  output logic ir_o
);
  import ubt_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic out;
  } ubt_irf_state_type;

  ubt_irf_state_type st_ff;
  ubt_irf_state_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (ir_i == st_ff.out) begin
      nxt_st.cnt = 8'h0;
    end else if (st_ff.cnt >= filt_i) begin
      nxt_st.out = ir_i;
      nxt_st.cnt = 8'h0;
    end else begin
      nxt_st.cnt = st_ff.cnt + 8'h1;
    end
  end

  // Idle infrared line is high
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '{cnt: 8'h0, out: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ir_o = st_ff.out;

  a_filter_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ir_i == ir_o || st_ff.cnt < filt_i) |=> $stable(ir_o))
    else $error("ir output changed before filter time");
endmodule : ubt_ir_filter
`default_nettype wire

// ---- rtl/ubt_regs.sv ----
// Baud, timing and card registers of the serial transceiver with their timers.
// Assumes the shift logic pulses tx_take_i, tx_done_i, rx_char_i, card_error_i.
`timescale 1ns/1ps
`default_nettype none
module ubt_regs (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire ubt_pkg::ubt_bus_type bus_i,
  output logic [31:0] rd_data_o,
  input wire logic tx_take_i,
  input wire logic tx_done_i,
  input wire logic rx_char_i,
  input wire logic card_error_i,
  input wire logic ir_rx_i,
  output logic [8:0] tx_char_o,
  output logic tx_sync_type_o,
  output logic tx_holding_free_o,
  output logic tx_guard_o,
  output logic [2:0] mode_o,
  output logic bit_tick_o,
  output logic ir_rx_filt_o,
  output logic irq_o
);
  import ubt_pkg::*;

  typedef struct packed {
    logic [8:0] tx_char;
    logic tx_sync;
    logic hold_free;
    logic [15:0] clock_divisor;
    logic [2:0] fraction_part;
    logic [15:0] to;
    logic [7:0] guard_value;
    logic [10:0] ratio;
    logic [7:0] errors;
    logic [7:0] irf;
    logic [2:0] mode;
    logic [2:0] status;
    logic [2:0] mask;
    logic [15:0] to_cnt;
    logic to_armed;
    ubt_tx_state_type tx_state;
    logic guard;
    logic [7:0] guard_cnt;
    logic [31:0] rd_data;
    logic irq;
  } ubt_state_type;

  ubt_state_type st;
  ubt_state_type nxt_st;
  ubt_baud_cfg_type baud_cfg;
  logic bit_tick;
  logic start_to;
  logic to_event;
  logic err_read;
  logic [2:0] events;

  // ----------------------------------------
  // Baud generator and infrared filter
  // ----------------------------------------
  assign baud_cfg = '{clock_divisor: st.clock_divisor, fraction_part: st.fraction_part,
                      sync: st.mode[MODE_SYNC],
                      over8: st.mode[MODE_OVER8], card: st.mode[MODE_CARD],
                      ratio: st.ratio};

  ubt_baud_gen u_baud (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .cfg_i(baud_cfg),
    .tick_o(bit_tick)
  );

  ubt_ir_filter u_irf (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .filt_i(st.irf),
    .ir_i(ir_rx_i),
    .ir_o(ir_rx_filt_o)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st;
    nxt_st.rd_data = 32'h0;
    start_to = 1'b0;
    to_event = 1'b0;
    events = 3'h0;
    err_read = bus_i.rd && (bus_i.addr == ADDR_ERR_CNT);

    if (tx_take_i && !st.hold_free) begin
      nxt_st.hold_free = 1'b1;
      events[IRQ_TX_FREE] = 1'b1;
    end

    if (bus_i.wr) begin
      case (bus_i.addr)
        ADDR_TX_HOLDING: begin
          // new character waits for the shifter
          nxt_st.tx_char = bus_i.wdata[TXC_MSB:0];
          nxt_st.tx_sync = bus_i.wdata[TXSYNC_BIT];
          nxt_st.hold_free = 1'b0;
          events[IRQ_TX_FREE] = 1'b0;
        end
        ADDR_BAUD_DIV: begin
          nxt_st.clock_divisor = bus_i.wdata[DIV_MSB:0];
          nxt_st.fraction_part = bus_i.wdata[FRAC_MSB:FRAC_LSB];
        end
        ADDR_RX_TIMEOUT: begin
          nxt_st.to = bus_i.wdata[TO_MSB:0];
        end
        ADDR_GUARD: begin
          nxt_st.guard_value = bus_i.wdata[GUARD_MSB:0];
        end
        ADDR_RATIO: begin
          nxt_st.ratio = bus_i.wdata[RATIO_MSB:0];
        end
        ADDR_IR_FILT: begin
          nxt_st.irf = bus_i.wdata[IRF_MSB:0];
        end
        ADDR_MODE: begin
          nxt_st.mode = bus_i.wdata[MODE_MSB:0];
          start_to = bus_i.wdata[MODE_START_TO_BIT];
        end
        ADDR_IRQ_STAT: begin
          nxt_st.status = st.status & ~bus_i.wdata[IRQ_MSB:0];
        end
        ADDR_IRQ_MASK: begin
          nxt_st.mask = bus_i.wdata[IRQ_MSB:0];
        end
        default: begin
        end
      endcase
    end

    // Receiver idle timer, restarted by command or by each character
    if (start_to || rx_char_i) begin
      nxt_st.to_cnt = st.to;
      nxt_st.to_armed = (st.to != 16'h0);
    end else if (st.to_armed && bit_tick) begin
      if (st.to_cnt <= 16'h1) begin
        to_event = 1'b1;
        nxt_st.to_armed = 1'b0;
        nxt_st.to_cnt = 16'h0;
      end else begin
        nxt_st.to_cnt = st.to_cnt - 16'h1;
      end
    end
    events[IRQ_TIMEOUT] = to_event;

    // Transmit timeguard
    case (st.tx_state)
      TXS_IDLE: begin
        if (tx_done_i && st.guard_value != 8'h0) begin
          nxt_st.tx_state = TXS_GUARD;
          nxt_st.guard = 1'b1;
          nxt_st.guard_cnt = st.guard_value;
        end
      end
      TXS_GUARD: begin
        if (bit_tick) begin
          if (st.guard_cnt <= 8'h1) begin
            nxt_st.tx_state = TXS_IDLE;
            nxt_st.guard = 1'b0;
            nxt_st.guard_cnt = 8'h0;
          end else begin
            nxt_st.guard_cnt = st.guard_cnt - 8'h1;
          end
        end
      end
      default: begin
        nxt_st.tx_state = TXS_IDLE;
        nxt_st.guard = 1'b0;
      end
    endcase

    // count errors; an error beside the clearing read survives
    events[IRQ_CARD_ERR] = card_error_i;
    if (err_read) begin
      nxt_st.errors = 8'h0;
    end
    if (card_error_i) begin
      if (err_read) begin
        nxt_st.errors = 8'h1;
      end else if (st.errors != ERR_MAX) begin
        nxt_st.errors = st.errors + 8'h1;
      end
    end

    // Sticky status: a new event beats a clear in the same cycle
    nxt_st.status = nxt_st.status | events;
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);

    if (bus_i.rd) begin
      case (bus_i.addr)
        ADDR_BAUD_DIV: begin
          nxt_st.rd_data[DIV_MSB:0] = st.clock_divisor;
          nxt_st.rd_data[FRAC_MSB:FRAC_LSB] = st.fraction_part;
        end
        ADDR_RX_TIMEOUT: begin
          nxt_st.rd_data[TO_MSB:0] = st.to;
        end
        ADDR_GUARD: begin
          nxt_st.rd_data[GUARD_MSB:0] = st.guard_value;
        end
        ADDR_RATIO: begin
          nxt_st.rd_data[RATIO_MSB:0] = st.ratio;
        end
        ADDR_ERR_CNT: begin
          nxt_st.rd_data[ERR_MSB:0] = st.errors;
        end
        ADDR_IR_FILT: begin
          nxt_st.rd_data[IRF_MSB:0] = st.irf;
        end
        ADDR_MODE: begin
          nxt_st.rd_data[MODE_MSB:0] = st.mode;
        end
        ADDR_IRQ_STAT: begin
          nxt_st.rd_data[IRQ_MSB:0] = st.status;
        end
        ADDR_IRQ_MASK: begin
          nxt_st.rd_data[IRQ_MSB:0] = st.mask;
        end
        default: begin
          // Holding register is write-only; unmapped reads give zero
          nxt_st.rd_data = 32'h0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
      st.hold_free <= 1'b1;
      st.ratio <= RATIO_RST;
      st.tx_state <= TXS_IDLE;
    end else begin
      st <= nxt_st;
    end
  end

  assign rd_data_o = st.rd_data;
  assign tx_char_o = st.tx_char;
  assign tx_sync_type_o = st.tx_sync;
  assign tx_holding_free_o = st.hold_free;
  assign tx_guard_o = st.guard;
  assign mode_o = st.mode;
  assign bit_tick_o = bit_tick;
  assign irq_o = st.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_hold_load: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == ADDR_TX_HOLDING) |=>
      (!tx_holding_free_o && tx_char_o == $past(bus_i.wdata[TXC_MSB:0])))
    else $error("holding register did not take character");

  a_sync_type: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (bus_i.wr && bus_i.addr == ADDR_TX_HOLDING) |=> tx_sync_type_o == $past(bus_i.wdata[TXSYNC_BIT]))
    else $error("sync type flag wrong");

  a_hold_free: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_take_i && !tx_holding_free_o && !(bus_i.wr && bus_i.addr == ADDR_TX_HOLDING)) |=>
      (tx_holding_free_o && st.status[IRQ_TX_FREE]))
    else $error("holding register not freed by take");

  a_hold_keep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!tx_take_i && !(bus_i.wr && bus_i.addr == ADDR_TX_HOLDING)) |=>
      ($stable(tx_char_o) && $stable(tx_sync_type_o) && $stable(tx_holding_free_o)))
    else $error("holding register changed without access");

  a_to_disabled: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((start_to || rx_char_i) && st.to == 16'h0) |=> !st.to_armed)
    else $error("timeout armed with zero value");

  a_to_restart: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((start_to || rx_char_i) && st.to != 16'h0) |=> (st.to_armed && st.to_cnt == $past(st.to)))
    else $error("timeout not loaded on restart");

  a_to_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st.to_armed && !bit_tick && !start_to && !rx_char_i) |=> (st.to_armed && $stable(st.to_cnt)))
    else $error("timeout counted without bit tick");

  a_to_count: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st.to_armed && bit_tick && st.to_cnt > 16'h1 && !start_to && !rx_char_i) |=>
      (st.to_armed && st.to_cnt == 16'($past(st.to_cnt) - 16'h1)))
    else $error("timeout count not stepped");

  a_to_fire: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st.to_armed && bit_tick && st.to_cnt <= 16'h1 && !start_to && !rx_char_i) |=>
      (!st.to_armed && st.status[IRQ_TIMEOUT]))
    else $error("timeout did not fire");

  a_guard_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_done_i && !tx_guard_o && st.guard_value == 8'h0) |=> !tx_guard_o)
    else $error("guard inserted with zero value");

  a_guard_on: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_done_i && !tx_guard_o && st.guard_value != 8'h0) |=>
      (tx_guard_o && st.guard_cnt == $past(st.guard_value)))
    else $error("guard not started");

  a_guard_count: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_guard_o && bit_tick && st.guard_cnt > 8'h1) |=>
      (tx_guard_o && st.guard_cnt == 8'($past(st.guard_cnt) - 8'h1)))
    else $error("guard count not stepped");

  a_guard_end: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_guard_o && bit_tick && st.guard_cnt <= 8'h1) |=> !tx_guard_o)
    else $error("guard did not end");

  a_err_count: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (card_error_i && !err_read && st.errors != ERR_MAX) |=> st.errors == 8'($past(st.errors) + 8'h1))
    else $error("error not counted");

  a_err_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (err_read && !card_error_i) |=> (st.errors == 8'h0 && rd_data_o[ERR_MSB:0] == $past(st.errors)))
    else $error("error count not cleared on read");

  a_err_read_hit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (err_read && card_error_i) |=> st.errors == 8'h1)
    else $error("error beside clearing read lost");

  a_err_saturate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (card_error_i && !err_read && st.errors == ERR_MAX) |=> st.errors == ERR_MAX)
    else $error("error count wrapped");
endmodule : ubt_regs
`default_nettype wire

// ---- test/ubt_line_model.sv ----
// Shift-side model: takes the held character and reports its end on the line.
// Assumes registered holding-free and guard flags from the register block.
`timescale 1ns/1ps
`default_nettype none
module ubt_line_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic holding_free_i,
  input wire logic guard_i,
  output logic tx_take_o,
  output logic tx_done_o
);
  int cnt;
  // ----------------------------------------
  // Take, then finish after a fixed time
  // ----------------------------------------
  always @(posedge ref_clk_i or posedge rst_i) begin
    tx_take_o <= 1'b0;
    tx_done_o <= 1'b0;
    if (rst_i) begin
      cnt <= 0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      tx_done_o <= (cnt == 1);
    end else if (en_i && !holding_free_i && !guard_i) begin
      tx_take_o <= 1'b1;
      cnt <= 10;
    end
  end
endmodule : ubt_line_model
`default_nettype wire

// ---- test/ubt_regs_tb.sv ----
// Self-checking bench for the baud, timing and card register block.
// Assumes ubt_pkg register map and the line model as the shift side.
`timescale 1ns/1ps
`default_nettype none
module ubt_regs_tb;
  import ubt_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  ubt_bus_type bus = '0;
  logic [31:0] rd_data;
  logic take, done, sync_t, free, guard, tick, ir_filt, irq;
  logic rx_char = 1'b0;
  logic card_err = 1'b0;
  logic ir = 1'b1;
  logic en = 1'b0;
  logic [8:0] tx_char;
  logic [2:0] mode;
  int miscompares = 0;
  int total_checks = 0;
  int gticks = 0;
  int n;
  logic [7:0] ra [7] = '{ADDR_BAUD_DIV, ADDR_RX_TIMEOUT, ADDR_GUARD, ADDR_RATIO, ADDR_IR_FILT, ADDR_TX_HOLDING, 8'h30};
  logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'h174, 32'h0, 32'h0, 32'h0};
  logic [31:0] rm [7] = '{32'h7ffff, 32'hffff, 32'hff, 32'h7ff, 32'hff, 32'h0, 32'h0};
  logic [2:0] bm [7] = '{3'h0, 3'h0, 3'h2, 3'h1, 3'h4, 3'h4, 3'h0};
  logic [31:0] bw [7] = '{32'h3, 32'h20003, 32'h10003, 32'h5, 32'h2, 32'h2, 32'h0};
  logic [10:0] br [7] = '{11'h1, 11'h1, 11'h1, 11'h1, 11'h3, 11'h0, 11'h1};
  int be [7] = '{48, 52, 25, 5, 6, 400, 400};

  always #20 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (guard === 1'b1 && tick === 1'b1) gticks++;

  ubt_regs ubt_regs_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus), .rd_data_o(rd_data),
    .tx_take_i(take), .tx_done_i(done), .rx_char_i(rx_char), .card_error_i(card_err), .ir_rx_i(ir),
    .tx_char_o(tx_char), .tx_sync_type_o(sync_t), .tx_holding_free_o(free), .tx_guard_o(guard),
    .mode_o(mode), .bit_tick_o(tick), .ir_rx_filt_o(ir_filt), .irq_o(irq));
  ubt_line_model ubt_line_model_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .en_i(en),
    .holding_free_i(free), .guard_i(guard), .tx_take_o(take), .tx_done_o(done));

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic results;
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    bus.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    bus.rd <= 1'b0;
    #1;
    chk(rd_data, e);
  endtask : rchk
  task automatic irq_is(input logic e);
    cyc(2);
    chk(irq, e);
  endtask : irq_is
  task automatic pulse_err(input int k);
    @(posedge ref_clk_i);
    card_err <= 1'b1;
    repeat (k) @(posedge ref_clk_i);
    card_err <= 1'b0;
    #1;
  endtask : pulse_err
  // Skips to one tick, then counts cycles to the next; 400 means no tick
  task automatic tick_gap(output int g);
    int i;
    i = 0;
    do begin cyc(1); i++; end while (tick !== 1'b1 && i < 400);
    g = 0;
    do begin cyc(1); g++; end while (tick !== 1'b1 && g < 400);
  endtask : tick_gap

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rchk(ADDR_ERR_CNT, 32'h0);
    for (int k = 0; k < 7; k++) begin
      rchk(ra[k], rv[k]);
      wr(ra[k], 32'hffffffff);
      rchk(ra[k], rm[k]);
    end
    for (int k = 0; k < 7; k++) begin
      wr(ADDR_MODE, {29'h0, bm[k]});
      wr(ADDR_RATIO, {21'h0, br[k]});
      wr(ADDR_BAUD_DIV, bw[k]);
      chk(mode, bm[k]);
      tick_gap(n);
      chk(n, be[k]);
    end
    // Timeout in sync mode: one bit tick every two cycles
    wr(ADDR_MODE, 32'h1);
    wr(ADDR_BAUD_DIV, 32'h2);
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_RX_TIMEOUT, 32'h0);
    wr(ADDR_MODE, 32'h9);
    cyc(60);
    chk(irq, 1'b0);
    wr(ADDR_RX_TIMEOUT, 32'h5);
    wr(ADDR_MODE, 32'h9);
    cyc(3);
    @(posedge ref_clk_i);
    rx_char <= 1'b1;
    @(posedge ref_clk_i);
    rx_char <= 1'b0;
    #1;
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk(n >= 7 && n <= 13, 1'b1);
    rchk(ADDR_IRQ_STAT, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1);
    irq_is(1'b0);
    // Holding register and guard time
    wr(ADDR_GUARD, 32'h0);
    @(posedge ref_clk_i);
    en <= 1'b1;
    cyc(20);
    wr(ADDR_TX_HOLDING, 32'h0055);
    chk({free, sync_t, tx_char}, {2'b00, 9'h055});
    cyc(20);
    chk(gticks, 0);
    rchk(ADDR_IRQ_STAT, 32'h4);
    wr(ADDR_IRQ_STAT, 32'h4);
    wr(ADDR_GUARD, 32'h3);
    wr(ADDR_TX_HOLDING, 32'h8041);
    chk({free, sync_t, tx_char}, {2'b01, 9'h041});
    cyc(40);
    chk(gticks, 3);
    // Error counter, interrupt mask and clear
    wr(ADDR_IRQ_MASK, 32'h2);
    pulse_err(3);
    rchk(ADDR_ERR_CNT, 32'h3);
    rchk(ADDR_ERR_CNT, 32'h0);
    irq_is(1'b1);
    wr(ADDR_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    wr(ADDR_IRQ_MASK, 32'h2);
    irq_is(1'b1);
    wr(ADDR_IRQ_STAT, 32'h2);
    irq_is(1'b0);
    pulse_err(300);
    rchk(ADDR_ERR_CNT, 32'hff);
    // Infrared filter: short glitch rejected, long low passes
    wr(ADDR_IR_FILT, 32'h2);
    @(posedge ref_clk_i);
    ir <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    ir <= 1'b1;
    cyc(6);
    chk(ir_filt, 1'b1);
    @(posedge ref_clk_i);
    ir <= 1'b0;
    cyc(8);
    chk(ir_filt, 1'b0);
    results();
  end

  // Whole run needs well under 10000 cycles
  initial begin
    #800000;
    miscompares++;
    results();
  end
endmodule : ubt_regs_tb
`default_nettype wire
